// ### verilog/irq_vec_pkg.sv
// Constants shared by the maskable interrupt vectoring block.
// Assumes a single 100 MHz system clock and APB register access.
package irq_vec_pkg;
   localparam logic [11:0] OFF_EDGE_CTRL = 12'h004;
   localparam logic [11:0] OFF_TRAP_CTRL = 12'h034;
   localparam logic [11:0] OFF_VEC_PAGE  = 12'h038;
   localparam logic [11:0] OFF_VEC_LOW   = 12'h03c;
   localparam logic [11:0] OFF_CORE_CTRL = 12'h040;
   localparam logic [11:0] OFF_STATUS    = 12'h044;
   localparam int EDGE_EN_BIT     = 3;
   localparam int EDGE_STATUS_BIT = 2;
   localparam int TRAP_FLAG_BIT   = 7;
   localparam int LEVEL2_EN_BIT   = 2;
   localparam int LEVEL1_EN_BIT   = 1;
   localparam int LEVEL0_EN_BIT   = 0;
   localparam int CORE_EI_BIT     = 0;
   localparam int CORE_DI_BIT     = 1;
   localparam logic [2:0] TRAP_CTRL_RESET = 3'h1;
   localparam logic [7:0] VEC_PAGE_RESET  = 8'h00;
   localparam logic [2:0] VEC_LOW_RESET   = 3'h0;
   localparam logic [15:0] LEVEL0_ADDR    = 16'h0038;
   localparam logic [15:0] TRAP_ADDR      = 16'h0000;
   localparam int NUM_VEC = 8;
   localparam logic [4:0] CODE_LEVEL1 = 5'h00;
   localparam logic [4:0] CODE_LEVEL2 = 5'h02;
   localparam logic [4:0] CODE_TIMER0 = 5'h04;
   localparam logic [4:0] CODE_TIMER1 = 5'h06;
   localparam logic [4:0] CODE_DMA0   = 5'h08;
   localparam logic [4:0] CODE_DMA1   = 5'h0a;
   localparam logic [4:0] CODE_SERIAL = 5'h0c;
   localparam logic [4:0] CODE_EDGE   = 5'h0e;
endpackage

// ### verilog/vec_prio.sv
// Fixed-priority encoder for the eight vectored sources.
// Assumes requests are already masked; bit 0 is the highest priority.
`timescale 1ns/100ps
`default_nettype none
module vec_prio (
   input  wire logic [7:0] req,
   output logic            any,
   output logic [2:0]      idx
);
   always_comb begin
      any = 1'b0;
      idx = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (req[i]) begin
            any = 1'b1;
            idx = 3'(i);
         end
      end
   end
endmodule
`default_nettype wire

// ### verilog/irq_vec.sv
// Maskable interrupt gating, prioritising and vector address build.
// Assumes the core pulses acknowledge, instruction and fetch strobes on SYS_CLK.
//
// What this block does
// - Level-0 request masked if global flag or level-0 enable is clear.
// - After reset level-0 enable set, global flag clear until enable instruction.
// - Level-0 acceptance pushes PC and fetches from address 38H.
// - Level-0 acceptance clears the global flag and its saved copy.
// - Undefined opcode during acknowledge raises the undefined-instruction trap.
// - Low vector byte is three low-select bits above a five-bit source code.
// - Codes: 00,02,04,06,08,0A,0C,0E hex for the eight vectored sources.
// - Priority order: level-1, level-2, timers, DMA, serial, edge input.
// - Level-1/2 blocked by clear global flag or their own enable bit.
// - Internal requests blocked by clear global flag or peripheral enable.
// - Reset clears global flag and level-1 and level-2 enables.
// - Reset clears the vector page register.
// - Reset clears the three low-select bits.
// - Vector page places tables on 256-byte boundaries; loaded by transfer path.
// - Low-select picks a 32-byte block inside the page.
// - Rising edge on edge input raises a request when its enable is set.
// - Edge status set while pin high, cleared by read while pin low.
// - Reset clears edge enable and edge status.
// - Disable instruction clears global flag, enable instruction sets it.
// - Trap/control bits 2..0 are level-2, level-1, level-0 enables.
// - Vector page forms the high byte of every vectored table address.
`timescale 1ns/100ps
`default_nettype none
module irq_vec (
   input  wire logic        SYS_CLK,
   input  wire logic        RESET,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        FIXED_RESTART_REQUEST,
   input  wire logic        VECTORED_REQUEST_ONE,
   input  wire logic        VECTORED_REQUEST_TWO,
   input  wire logic        EDGE_INPUT_PIN,
   input  wire logic [4:0]  PERIPH_REQ,
   input  wire logic [4:0]  PERIPH_EN,
   input  wire logic        ENABLE_INTERRUPTS_INSTRUCTION,
   input  wire logic        DISABLE_INTERRUPTS_INSTRUCTION,
   input  wire logic        VEC_PAGE_LOAD,
   input  wire logic [7:0]  VEC_PAGE_DATA,
   input  wire logic        ACK,
   input  wire logic        UNDEFINED_FETCH,
   output logic             IRQ_PENDING,
   output logic             PUSH_PC,
   output logic             VECTOR_VALID,
   output logic             VECTOR_INDIRECT,
   output logic [15:0]      VECTOR_ADDR,
   output logic             TRAP_RAISE,
   output logic [7:0]       VEC_PAGE
);
   typedef struct packed {
      logic        pin_meta;
      logic        pin_sync;
      logic        pin_last;
      logic        edge_en;
      logic        edge_status;
      logic        edge_pend;
      logic        global_mask_flag;
      logic        saved_mask_flag;
      logic [2:0]  trap_ctrl;
      logic        trap_flag;
      logic [7:0]  vec_page;
      logic [2:0]  vector_low_select;
      logic        in_ack;
      logic        push_pc;
      logic        vec_valid;
      logic        vec_indirect;
      logic [15:0] vec_addr;
      logic        trap_raise;
      logic [31:0] prdata;
      logic [2:0]  pin_irq_meta;
      logic [2:0]  pin_irq_sync;
   } state_t;

   state_t s;
   state_t next_s;

   logic [7:0] raw_req;
   logic [7:0] masked;
   logic       any_vec;
   logic [2:0] win;
   logic       level0_ok;
   logic       setup_w;
   logic       access_w;
   logic       access_r;

   function automatic logic [4:0] code_of(input logic [2:0] i);
      case (i)
         3'h0:    code_of = irq_vec_pkg::CODE_LEVEL1;
         3'h1:    code_of = irq_vec_pkg::CODE_LEVEL2;
         3'h2:    code_of = irq_vec_pkg::CODE_TIMER0;
         3'h3:    code_of = irq_vec_pkg::CODE_TIMER1;
         3'h4:    code_of = irq_vec_pkg::CODE_DMA0;
         3'h5:    code_of = irq_vec_pkg::CODE_DMA1;
         3'h6:    code_of = irq_vec_pkg::CODE_SERIAL;
         default: code_of = irq_vec_pkg::CODE_EDGE;
      endcase
   endfunction

   // The three request pins are active low, so their synced level is inverted.
   // Bit 0 is level-1 and bit 7 the edge input, so index order is priority order.
   assign raw_req = {s.edge_pend, PERIPH_REQ & PERIPH_EN,
                     ~s.pin_irq_sync[2], ~s.pin_irq_sync[1]};
   assign masked = s.global_mask_flag ?
                   (raw_req & {6'h3f, s.trap_ctrl[irq_vec_pkg::LEVEL2_EN_BIT],
                               s.trap_ctrl[irq_vec_pkg::LEVEL1_EN_BIT]}) : 8'h00;
   assign level0_ok = s.global_mask_flag & s.trap_ctrl[irq_vec_pkg::LEVEL0_EN_BIT]
                      & ~s.pin_irq_sync[0];

   vec_prio prio (
      .req (masked),
      .any (any_vec),
      .idx (win)
   );

   assign access_w = PSEL & PENABLE & PWRITE;
   assign access_r = PSEL & PENABLE & ~PWRITE;
   assign setup_w  = PSEL & ~PENABLE & ~PWRITE;

   always_comb begin
      next_s = s;
      next_s.pin_meta = EDGE_INPUT_PIN;
      next_s.pin_sync = s.pin_meta;
      next_s.pin_last = s.pin_sync;
      next_s.pin_irq_meta = {VECTORED_REQUEST_TWO, VECTORED_REQUEST_ONE, FIXED_RESTART_REQUEST};
      next_s.pin_irq_sync = s.pin_irq_meta;
      next_s.push_pc = 1'b0;
      next_s.vec_valid = 1'b0;
      next_s.trap_raise = 1'b0;
      if (ENABLE_INTERRUPTS_INSTRUCTION) begin
         next_s.global_mask_flag = 1'b1;
         next_s.saved_mask_flag = 1'b1;
      end
      if (DISABLE_INTERRUPTS_INSTRUCTION) begin
         next_s.global_mask_flag = 1'b0;
         next_s.saved_mask_flag = 1'b0;
      end
      if (VEC_PAGE_LOAD) begin
         next_s.vec_page = VEC_PAGE_DATA;
      end
      // The read clears status only when the pin is low; a high pin wins.
      if (setup_w && PADDR == irq_vec_pkg::OFF_EDGE_CTRL && !s.pin_sync) begin
         next_s.edge_status = 1'b0;
      end
      if (s.pin_sync) begin
         next_s.edge_status = 1'b1;
      end
      next_s.in_ack = 1'b0;
      if (ACK) begin
         next_s.in_ack = 1'b1;
         if (level0_ok) begin
            next_s.push_pc = 1'b1;
            next_s.vec_valid = 1'b1;
            next_s.vec_indirect = 1'b0;
            next_s.vec_addr = irq_vec_pkg::LEVEL0_ADDR;
            next_s.global_mask_flag = 1'b0;
            next_s.saved_mask_flag = 1'b0;
         end else if (any_vec) begin
            next_s.push_pc = 1'b1;
            next_s.vec_valid = 1'b1;
            next_s.vec_indirect = 1'b1;
            next_s.vec_addr = {s.vec_page, s.vector_low_select, code_of(win)};
            next_s.global_mask_flag = 1'b0;
            next_s.saved_mask_flag = 1'b0;
            if (win == 3'h7) begin
               next_s.edge_pend = 1'b0;
            end
         end
      end
      // A new edge in the cycle that services the old one must not be lost.
      if (s.edge_en && s.pin_sync && !s.pin_last) begin
         next_s.edge_pend = 1'b1;
      end
      if (UNDEFINED_FETCH && (s.in_ack || ACK)) begin
         next_s.trap_raise = 1'b1;
         next_s.trap_flag = 1'b1;
         next_s.push_pc = 1'b1;
         next_s.vec_valid = 1'b1;
         next_s.vec_indirect = 1'b0;
         next_s.vec_addr = irq_vec_pkg::TRAP_ADDR;
      end
      if (access_w) begin
         case (PADDR)
            irq_vec_pkg::OFF_EDGE_CTRL: begin
               next_s.edge_en = PWDATA[irq_vec_pkg::EDGE_EN_BIT];
            end
            irq_vec_pkg::OFF_TRAP_CTRL: begin
               next_s.trap_ctrl = PWDATA[2:0];
               if (!PWDATA[irq_vec_pkg::TRAP_FLAG_BIT] && !next_s.trap_raise) begin
                  next_s.trap_flag = 1'b0;
               end
            end
            irq_vec_pkg::OFF_VEC_LOW: begin
               next_s.vector_low_select = PWDATA[7:5];
            end
            irq_vec_pkg::OFF_CORE_CTRL: begin
               if (PWDATA[irq_vec_pkg::CORE_EI_BIT]) begin
                  next_s.global_mask_flag = 1'b1;
                  next_s.saved_mask_flag = 1'b1;
               end
               if (PWDATA[irq_vec_pkg::CORE_DI_BIT]) begin
                  next_s.global_mask_flag = 1'b0;
                  next_s.saved_mask_flag = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      next_s.prdata = 32'h0;
      if (setup_w) begin
         case (PADDR)
            irq_vec_pkg::OFF_EDGE_CTRL:
               next_s.prdata = {28'h0, s.edge_en, s.edge_status, 2'h0};
            irq_vec_pkg::OFF_TRAP_CTRL:
               next_s.prdata = {24'h0, s.trap_flag, 4'h0, s.trap_ctrl};
            irq_vec_pkg::OFF_VEC_PAGE:
               next_s.prdata = {24'h0, s.vec_page};
            irq_vec_pkg::OFF_VEC_LOW:
               next_s.prdata = {24'h0, s.vector_low_select, 5'h0};
            irq_vec_pkg::OFF_CORE_CTRL:
               next_s.prdata = {30'h0, s.saved_mask_flag, s.global_mask_flag};
            irq_vec_pkg::OFF_STATUS:
               next_s.prdata = {23'h0, level0_ok, masked};
            default:
               next_s.prdata = 32'h0;
         endcase
      end
      if (RESET) begin
         next_s = '0;
         next_s.trap_ctrl = irq_vec_pkg::TRAP_CTRL_RESET;
         next_s.vec_page = irq_vec_pkg::VEC_PAGE_RESET;
         next_s.vector_low_select = irq_vec_pkg::VEC_LOW_RESET;
         next_s.edge_en = 1'b0;
         next_s.edge_status = 1'b0;
         next_s.pin_irq_meta = 3'h7;
         next_s.pin_irq_sync = 3'h7;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      s <= next_s;
   end

   // Reads see state from the setup cycle, so access always takes one cycle.
   assign PREADY = 1'b1;
   assign PSLVERR = 1'b0;
   assign PRDATA = s.prdata;
   assign IRQ_PENDING = level0_ok | any_vec;
   assign PUSH_PC = s.push_pc;
   assign VECTOR_VALID = s.vec_valid;
   assign VECTOR_INDIRECT = s.vec_indirect;
   assign VECTOR_ADDR = s.vec_addr;
   assign TRAP_RAISE = s.trap_raise;
   assign VEC_PAGE = s.vec_page;

   // Each check but mask_global_a looks one cycle past the strobe, where the registered answer stands.
   level0_mask_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (ACK && !(s.global_mask_flag && s.trap_ctrl[irq_vec_pkg::LEVEL0_EN_BIT]))
      |=> !(s.vec_valid && !s.vec_indirect && !s.trap_raise))
      else $error("level-0 accepted while masked");

   level0_addr_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (ACK && level0_ok && !UNDEFINED_FETCH) |=> (s.vec_addr == 16'h0038 && s.push_pc))
      else $error("level-0 vector not 38H");

   level0_clear_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (ACK && level0_ok && !access_w) |=> (!s.global_mask_flag && !s.saved_mask_flag))
      else $error("flags not cleared on accept");

   // A vectored accept masks further requests just as a level-0 accept does.
   vec_clear_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (ACK && any_vec && !access_w) |=> (!s.global_mask_flag && !s.saved_mask_flag))
      else $error("flags not cleared on vectored accept");

   trap_raise_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (ACK && UNDEFINED_FETCH) |=> (s.trap_raise && s.trap_flag))
      else $error("trap not raised");

   vec_byte_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (ACK && !level0_ok && any_vec && !UNDEFINED_FETCH) |=>
      (s.vec_addr[7:5] == $past(s.vector_low_select) && s.vec_addr[15:8] == $past(s.vec_page)
       && s.vec_addr[0] == 1'b0))
      else $error("vector byte wrong");

   // The chosen source must be requesting and no source above it may be requesting.
   prio_order_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (ACK && !level0_ok && any_vec && !UNDEFINED_FETCH) |=>
      (s.vec_addr[4] == 1'b0 && (($past(masked) >> s.vec_addr[3:1]) & 8'h01) == 8'h01
       && ($past(masked) & ((8'h01 << s.vec_addr[3:1]) - 8'h01)) == 8'h00))
      else $error("vector priority wrong");

   mask_global_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      !s.global_mask_flag |-> (masked == 8'h00 && !level0_ok))
      else $error("request passed with flag clear");

   // Only the trap may leave a vector while the global flag is clear.
   mask_vec_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      !s.global_mask_flag |=> (!s.vec_valid || s.trap_raise))
      else $error("vector given with flag clear");

   reset_vals_a: assert property (@(posedge SYS_CLK)
      RESET |=> (s.trap_ctrl == 3'h1 && s.vec_page == 8'h00 && !s.global_mask_flag
                 && s.vector_low_select == 3'h0 && !s.edge_en && !s.edge_status))
      else $error("reset values wrong");

   page_load_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      VEC_PAGE_LOAD |=> s.vec_page == $past(VEC_PAGE_DATA))
      else $error("vector page not loaded");

   low_write_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (access_w && PADDR == irq_vec_pkg::OFF_VEC_LOW)
      |=> s.vector_low_select == $past(PWDATA[7:5]))
      else $error("low select not written");

   edge_req_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (s.edge_en && s.pin_sync && !s.pin_last) |=> s.edge_pend)
      else $error("edge request missed");

   edge_hold_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      s.pin_sync |=> s.edge_status)
      else $error("edge status not set by high pin");

   edge_clear_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (setup_w && PADDR == irq_vec_pkg::OFF_EDGE_CTRL && !s.pin_sync) |=> !s.edge_status)
      else $error("edge status not cleared by read");

   // Level sources hold themselves; the latched edge must survive a higher winner.
   edge_keep_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (ACK && !level0_ok && any_vec && win != 3'h7 && s.edge_pend) |=> s.edge_pend)
      else $error("edge request lost");

   ei_set_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (ENABLE_INTERRUPTS_INSTRUCTION && !DISABLE_INTERRUPTS_INSTRUCTION && !ACK && !access_w)
      |=> s.global_mask_flag)
      else $error("enable instruction ignored");

   trap_ctrl_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (access_w && PADDR == irq_vec_pkg::OFF_TRAP_CTRL)
      |=> s.trap_ctrl == $past(PWDATA[2:0]))
      else $error("trap control not written");

   level0_cov: cover property (@(posedge SYS_CLK) ACK && level0_ok);
   vectored_cov: cover property (@(posedge SYS_CLK) ACK && !level0_ok && any_vec);
   edge_cov: cover property (@(posedge SYS_CLK) ACK && any_vec && win == 3'h7);
   trap_cov: cover property (@(posedge SYS_CLK) s.trap_raise);
endmodule
`default_nettype wire

// ### testbench/core_model.sv
// Core-side model: acknowledge strobe and undefined-fetch strobe.
// Assumes the block's clock, reset and combined pending flag.
`timescale 1ns/100ps
`default_nettype none
module core_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       go,
   input  wire logic       bad,
   input  wire logic [1:0] dly,
   input  wire logic       pend,
   output logic            ack,
   output logic            undef
);
   logic       armed;
   logic [1:0] cnt;
   // A slow core lets dly cycles pass after it sees a request, as a busy core would.
   always @(posedge clk) begin
      ack <= 1'b0;
      undef <= 1'b0;
      if (go)
         armed <= 1'b1;
      if (rst) begin
         armed <= 1'b0;
         cnt <= 2'h0;
      end else if (armed && pend) begin
         cnt <= cnt + 2'h1;
         if (cnt == dly) begin
            ack <= 1'b1;
            undef <= bad;
            armed <= 1'b0;
            cnt <= 2'h0;
         end
      end
   end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the interrupt vectoring block.
// Assumes the core model beside it and an APB slave that may insert waits.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        clk, rst, psel, pen, pwr, pready, pslverr;
   logic        r0, r1, r2, pin, ei, di, ld, go, bad;
   logic        ack, undef, pend, push, vv, vind, trap;
   logic [11:0] paddr;
   logic [31:0] pwd, prd, rd;
   logic [4:0]  preq, pen_m;
   logic [7:0]  pdata, page;
   logic [15:0] vaddr;
   logic [2:0]  low;
   logic [1:0]  dly;
   logic [17:0] exp_q[$];
   logic [17:0] e;
   int          n_errors, cmp_count, i, k;
   irq_vec DUT (
      .SYS_CLK                        (clk),
      .RESET                          (rst),
      .PSEL                           (psel),
      .PENABLE                        (pen),
      .PWRITE                         (pwr),
      .PADDR                          (paddr),
      .PWDATA                         (pwd),
      .PRDATA                         (prd),
      .PREADY                         (pready),
      .PSLVERR                        (pslverr),
      .FIXED_RESTART_REQUEST          (r0),
      .VECTORED_REQUEST_ONE           (r1),
      .VECTORED_REQUEST_TWO           (r2),
      .EDGE_INPUT_PIN                 (pin),
      .PERIPH_REQ                     (preq),
      .PERIPH_EN                      (pen_m),
      .ENABLE_INTERRUPTS_INSTRUCTION  (ei),
      .DISABLE_INTERRUPTS_INSTRUCTION (di),
      .VEC_PAGE_LOAD                  (ld),
      .VEC_PAGE_DATA                  (pdata),
      .ACK                            (ack),
      .UNDEFINED_FETCH                (undef),
      .IRQ_PENDING                    (pend),
      .PUSH_PC                        (push),
      .VECTOR_VALID                   (vv),
      .VECTOR_INDIRECT                (vind),
      .VECTOR_ADDR                    (vaddr),
      .TRAP_RAISE                     (trap),
      .VEC_PAGE                       (page)
   );
   core_model core (
      .clk   (clk),
      .rst   (rst),
      .go    (go),
      .bad   (bad),
      .dly   (dly),
      .pend  (pend),
      .ack   (ack),
      .undef (undef)
   );
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      cmp_count++;
      if (got !== ex) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic wrap_up;
      if (n_errors == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int t;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      for (t = 0; t < 16; t++) begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      if (t == 16) begin
         chk("apb timeout", 1, 0);
         wrap_up();
      end
      rd = prd;
      chk("slverr", 0, pslverr);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic setf(input logic on);
      @(posedge clk);
      ei <= on;
      di <= !on;
      @(posedge clk);
      ei <= 1'b0;
      di <= 1'b0;
      @(posedge clk);
   endtask
   task automatic take(input logic [17:0] x, input logic b);
      int t;
      exp_q.push_back(x);
      bad <= b;
      dly <= 2'($urandom);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (t = 0; t < 20 && exp_q.size() > 0; t++)
         @(posedge clk);
      if (exp_q.size() > 0) begin
         chk("ack timeout", 1, 0);
         wrap_up();
      end
   endtask
   // Each vector result is matched against the oldest expectation on the queue.
   always @(posedge clk) begin
      if (vv === 1'b1 && exp_q.size() == 0)
         chk("vector count", 0, 1);
      else if (vv === 1'b1) begin
         e = exp_q.pop_front();
         chk("vector address", {16'h0, e[15:0]}, {16'h0, vaddr});
         chk("push", 1, push);
         chk("trap", !e[17], trap);
         if (e[17])
            chk("indirect", e[16], vind);
      end
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      {rst, psel, pen, pwr, ei, di, ld, go, bad} = 9'h100;
      {r0, r1, r2, pin} = 4'he;
      {paddr, pwd, preq, pen_m, pdata, dly} = '0;
      n_errors = 0;
      cmp_count = 0;
      void'($urandom(32'h5962));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      apb(0, irq_vec_pkg::OFF_TRAP_CTRL, 0);
      chk("trap ctrl", 32'h1, rd & 32'h87);
      apb(0, irq_vec_pkg::OFF_VEC_LOW, 0);
      chk("low select", 0, rd & 32'he0);
      apb(0, irq_vec_pkg::OFF_CORE_CTRL, 0);
      chk("core flags", 0, rd & 32'h3);
      apb(0, irq_vec_pkg::OFF_EDGE_CTRL, 0);
      chk("edge ctrl", 0, rd & 32'hc);
      apb(1, irq_vec_pkg::OFF_VEC_PAGE, 32'hff);
      apb(0, 12'h100, 0);
      chk("unmapped", 0, rd);
      chk("page", 0, page);
      pin <= 1'b1;
      repeat (4) @(posedge clk);
      apb(0, irq_vec_pkg::OFF_EDGE_CTRL, 0);
      chk("edge status", 32'h4, rd & 32'h4);
      pin <= 1'b0;
      repeat (4) @(posedge clk);
      apb(0, irq_vec_pkg::OFF_EDGE_CTRL, 0);
      chk("edge status", 32'h4, rd & 32'h4);
      apb(0, irq_vec_pkg::OFF_EDGE_CTRL, 0);
      chk("edge status", 0, rd & 32'h4);
      for (i = 0; i < 6; i++) begin
         k = $urandom;
         apb(1, irq_vec_pkg::OFF_TRAP_CTRL, {29'h0, k[2:1], 1'b0});
         preq <= k[7:3];
         pen_m <= k[12:8];
         r1 <= k[13];
         r2 <= k[14];
         repeat (4) @(posedge clk);
         chk("masked", 0, pend);
         setf(1);
         chk("pending", |{preq & pen_m, ~r1 & k[1], ~r2 & k[2]}, pend);
         setf(0);
      end
      {r1, r2, preq} <= {2'h3, 5'h0};
      r0 <= 1'b0;
      apb(1, irq_vec_pkg::OFF_TRAP_CTRL, 0);
      setf(1);
      chk("level0 off", 0, pend);
      apb(1, irq_vec_pkg::OFF_TRAP_CTRL, 1);
      @(posedge clk);
      chk("level0 on", 1, pend);
      apb(0, irq_vec_pkg::OFF_CORE_CTRL, 0);
      chk("core flags", 3, rd & 32'h3);
      take({2'b10, 16'h0038}, 0);
      apb(0, irq_vec_pkg::OFF_CORE_CTRL, 0);
      chk("core flags", 0, rd & 32'h3);
      setf(1);
      take({2'b00, 16'h0000}, 1);
      apb(0, irq_vec_pkg::OFF_TRAP_CTRL, 0);
      chk("trap flag", 32'h80, rd & 32'h80);
      // Level-0 stays asserted with its enable off, so each vector below proves it masked.
      apb(1, irq_vec_pkg::OFF_TRAP_CTRL, 32'h6);
      setf(1);
      setf(0);
      apb(0, irq_vec_pkg::OFF_CORE_CTRL, 0);
      chk("core flags", 0, rd & 32'h1);
      pdata <= 8'($urandom);
      ld <= 1'b1;
      @(posedge clk);
      ld <= 1'b0;
      @(posedge clk);
      chk("page", pdata, page);
      low = 3'($urandom);
      apb(1, irq_vec_pkg::OFF_VEC_LOW, {24'h0, low, 5'h0});
      apb(1, irq_vec_pkg::OFF_EDGE_CTRL, 32'h8);
      {r1, r2, preq, pen_m, pin} <= {2'h0, 5'h1f, 5'h1f, 1'b1};
      repeat (4) @(posedge clk);
      for (i = 0; i < 8; i++) begin
         setf(1);
         take({2'b11, pdata, low, 5'(2 * i)}, 0);
         if (i == 0)
            r1 <= 1'b1;
         else if (i == 1)
            r2 <= 1'b1;
         else if (i < 7)
            preq[i - 2] <= 1'b0;
         repeat (4) @(posedge clk);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
